// [src/acl_rule_match_control.v]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Mode 00 disables the rule, 01 layer 2 MAC, 10 layer 3 IP.
// - Rule bytes reached only via control, offset and indirect data registers.
// - L2 enable 00 takes 11 action bits as count for MAC+type matches.
// - Forward bit 4 picks count unit: 0 microseconds, 1 milliseconds.
// - Forward bit 3 low: load count, decrement per unit, interrupt on expiry.
// - Forward bit 3 high: count matches, interrupt at terminal count, then reset.
// - L2 enable 01 includes MAC address in the match.
// - L2 enable 10 uses MAC address for the match.
// - L2 enable 11 tests both MAC address and EtherType.
// - L3 enable 00 reserved; 01 tests masked IP address or protocol.
// - L3 enable 10 compares source and destination; 11 reserved.
// - Mode 11 enable 00 performs protocol comparison.
// - Mode 11 enable 01 and 10 both select port comparison.
// - Mode 11 enable 11 compares TCP sequence number.
// - Address side bit 0 selects destination, 1 selects source.
// - Polarity bit 0 matches on inequality, 1 on equality.
module acl_rule_match_control (
	// Clock and reset
	input wire clk_sys_i,
	input wire srst_i,
	// Register port
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	// Packet fields
	input wire pkt_valid_i,
	input wire [47:0] pkt_da_i,
	input wire [47:0] pkt_sa_i,
	input wire [15:0] pkt_type_i,
	input wire [31:0] pkt_ip_da_i,
	input wire [31:0] pkt_ip_sa_i,
	input wire [7:0] pkt_proto_i,
	input wire [15:0] pkt_dport_i,
	input wire [15:0] pkt_sport_i,
	input wire [31:0] pkt_seq_i,
	// Results
	output reg match_o,
	output reg match_valid_o,
	output reg [1:0] match_kind_o,
	output reg irq_o,
	output reg [10:0] count_o
);
`include "acl_rule_map.vh"
	localparam K_NONE = 2'h0;
	localparam K_L2 = 2'h1;
	localparam K_L3 = 2'h2;
	localparam K_L4 = 2'h3;

	// ----------------------------------------
	// Indirect access and rule storage
	// ----------------------------------------
	reg [7:0] ctrl_q;
	reg [7:0] offs_q;
	reg [7:0] mode_q;
	reg [47:0] mac_q;
	reg [15:0] type_q;
	reg [7:0] act_hi_q;
	reg [7:0] act_lo_q;
	reg [7:0] fwd_q;
	wire acl_sel = (ctrl_q[7:5] == `IND_SEL_ACL);
	wire [1:0] md = mode_q[`MD_HI:`MD_LO];
	wire [1:0] match_enable_select = mode_q[`ENB_HI:`ENB_LO];
	wire sd = mode_q[`SD_BIT];
	wire eq = mode_q[`EQ_BIT];
	wire [10:0] count_val = {act_hi_q[2:0], act_lo_q};
	integer i;

	// Offset falls inside the MAC address bytes
	function in_mac_range;
		input [7:0] off;
		begin
			in_mac_range = (off >= `OFF_MAC0) && (off < `OFF_TYPE0);
		end
	endfunction

	function [7:0] entry_byte;
		input [7:0] off;
		begin
			entry_byte = 8'h00;
			if (off == `OFF_MODE)
				entry_byte = mode_q;
			else if (in_mac_range(off))
				entry_byte = mac_q[8'h2f - ((off - `OFF_MAC0) * 8'h08) -: 8];
			else if (off == `OFF_TYPE0)
				entry_byte = type_q[15:8];
			else if (off == `OFF_TYPE0 + 8'h01)
				entry_byte = type_q[7:0];
			else if (off == `OFF_ACT_HI)
				entry_byte = act_hi_q;
			else if (off == `OFF_ACT_LO)
				entry_byte = act_lo_q;
			else if (off == `OFF_FWD)
				entry_byte = fwd_q;
		end
	endfunction

	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			ctrl_q <= 8'h00;
			offs_q <= 8'h00;
			mode_q <= `MODE_RESET;
			mac_q <= 48'h000000000000;
			type_q <= 16'h0000;
			act_hi_q <= 8'h00;
			act_lo_q <= 8'h00;
			fwd_q <= 8'h00;
			reg_rdata_o <= 8'h00;
		end else begin
			if (reg_wr_i) begin
				if (reg_addr_i == `IND_CTRL_ADDR)
					ctrl_q <= reg_wdata_i;
				else if (reg_addr_i == `IND_OFFS_ADDR)
					offs_q <= reg_wdata_i;
				else if (reg_addr_i == `IND_DATA_ADDR && acl_sel) begin
					if (offs_q == `OFF_MODE)
						mode_q <= {2'h0, reg_wdata_i[5:0]};
					else if (in_mac_range(offs_q)) begin
						for (i = 0; i < 6; i = i + 1)
							if (offs_q == `OFF_MAC0 + i[7:0])
								mac_q[47 - i * 8 -: 8] <= reg_wdata_i;
					end else if (offs_q == `OFF_TYPE0)
						type_q[15:8] <= reg_wdata_i;
					else if (offs_q == `OFF_TYPE0 + 8'h01)
						type_q[7:0] <= reg_wdata_i;
					else if (offs_q == `OFF_ACT_HI)
						act_hi_q <= reg_wdata_i;
					else if (offs_q == `OFF_ACT_LO)
						act_lo_q <= reg_wdata_i;
					else if (offs_q == `OFF_FWD)
						fwd_q <= reg_wdata_i;
				end
			end
			if (reg_rd_i) begin
				if (reg_addr_i == `IND_CTRL_ADDR)
					reg_rdata_o <= ctrl_q;
				else if (reg_addr_i == `IND_OFFS_ADDR)
					reg_rdata_o <= offs_q;
				else if (reg_addr_i == `IND_DATA_ADDR && acl_sel)
					reg_rdata_o <= entry_byte(offs_q);
				else
					reg_rdata_o <= 8'h00;
			end
		end
	end

	// ----------------------------------------
	// Match evaluation
	// ----------------------------------------
	reg raw_eq;
	reg cmp_ok;
	reg [1:0] kind;
	reg l2_count;
	wire [47:0] mac_pick = sd ? pkt_sa_i : pkt_da_i;
	wire [31:0] ip_pick = sd ? pkt_ip_sa_i : pkt_ip_da_i;
	wire [15:0] port_pick = sd ? pkt_sport_i : pkt_dport_i;
	wire [31:0] ip_mask = {mac_q[31:0]};

	// MAC compare, optionally qualified by EtherType
	function l2_eq;
		input [47:0] mac_a;
		input [47:0] mac_b;
		input [15:0] type_a;
		input [15:0] type_b;
		input use_type;
		begin
			l2_eq = (mac_a == mac_b) && (!use_type || type_a == type_b);
		end
	endfunction

	always @* begin
		raw_eq = 1'b0;
		cmp_ok = 1'b0;
		kind = K_NONE;
		l2_count = 1'b0;
		case (md)
			`MD_L2: begin
				kind = K_L2;
				cmp_ok = 1'b1;
				case (match_enable_select)
					2'h0: begin
						l2_count = 1'b1;
						raw_eq = l2_eq(mac_pick, mac_q, pkt_type_i, type_q, 1'b1);
					end
					2'h1: raw_eq = l2_eq(mac_pick, mac_q, pkt_type_i, type_q, 1'b0);
					2'h2: raw_eq = l2_eq(mac_pick, mac_q, pkt_type_i, type_q, 1'b0);
					default: raw_eq = l2_eq(mac_pick, mac_q, pkt_type_i, type_q, 1'b1);
				endcase
			end
			`MD_L3: begin
				kind = K_L3;
				case (match_enable_select)
					2'h1: begin
						cmp_ok = 1'b1;
						// Zero mask turns the test into a protocol compare
						if (ip_mask != 32'h00000000)
							raw_eq = (ip_pick & ip_mask) == (mac_q[47:16] & ip_mask);
						else
							raw_eq = (pkt_proto_i == type_q[7:0]);
					end
					2'h2: begin
						cmp_ok = 1'b1;
						raw_eq = (pkt_ip_sa_i == pkt_ip_da_i);
					end
					default: cmp_ok = 1'b0;
				endcase
			end
			`MD_L4: begin
				kind = K_L4;
				cmp_ok = 1'b1;
				case (match_enable_select)
					2'h0: raw_eq = (pkt_proto_i == type_q[7:0]);
					2'h1: raw_eq = (port_pick == type_q);
					2'h2: raw_eq = (port_pick == type_q);
					default: raw_eq = (pkt_seq_i == mac_q[31:0]);
				endcase
			end
			default: kind = K_NONE;
		endcase
	end

	wire hit = cmp_ok && (eq ? raw_eq : !raw_eq);

	// ----------------------------------------
	// Count and time-out counter
	// ----------------------------------------
	wire us_tick;
	wire ms_tick;
	acl_tick_gen u_tick (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.us_tick_o(us_tick),
		.ms_tick_o(ms_tick)
	);
	wire unit_tick = fwd_q[`FWD_UNIT_BIT] ? ms_tick : us_tick;
	wire cnt_mode = (md == `MD_L2) && l2_count;
	wire pkt_hit = pkt_valid_i && cnt_mode && hit;
	reg cnt_mode_q;

	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			count_o <= 11'h000;
			irq_o <= 1'b0;
			cnt_mode_q <= 1'b0;
			match_o <= 1'b0;
			match_valid_o <= 1'b0;
			match_kind_o <= K_NONE;
		end else begin
			match_valid_o <= pkt_valid_i && kind != K_NONE;
			match_o <= pkt_valid_i && hit;
			match_kind_o <= kind;
			cnt_mode_q <= cnt_mode;
			irq_o <= 1'b0;
			if (!cnt_mode) begin
				count_o <= 11'h000;
			end else if (!fwd_q[`FWD_ALG_BIT]) begin
				if (!cnt_mode_q || pkt_hit) begin
					count_o <= count_val;
				end else if (unit_tick && count_o != 11'h000) begin
					count_o <= count_o - 11'h001;
					if (count_o == 11'h001)
						irq_o <= 1'b1;
				end
			end else if (pkt_hit) begin
				if (count_o + 11'h001 >= count_val) begin
					count_o <= 11'h000;
					irq_o <= 1'b1;
				end else begin
					count_o <= count_o + 11'h001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [src/acl_rule_map.vh]
`ifndef ACL_RULE_MAP_VH
`define ACL_RULE_MAP_VH
// ----------------------------------------
// Indirect access registers
// ----------------------------------------
`define IND_CTRL_ADDR 8'h6e
`define IND_OFFS_ADDR 8'h6f
`define IND_DATA_ADDR 8'ha0
`define IND_SEL_ACL 3'h2
// ----------------------------------------
// Rule entry byte offsets
// ----------------------------------------
`define OFF_MODE 8'h01
`define OFF_MAC0 8'h02
`define OFF_TYPE0 8'h08
`define OFF_ACT_HI 8'h0a
`define OFF_ACT_LO 8'h0b
`define OFF_FWD 8'h0c
// ----------------------------------------
// Mode byte and forward byte fields
// ----------------------------------------
`define MODE_RESET 8'h00
`define MD_HI 5
`define MD_LO 4
`define ENB_HI 3
`define ENB_LO 2
`define SD_BIT 1
`define EQ_BIT 0
`define MD_OFF 2'h0
`define MD_L2 2'h1
`define MD_L3 2'h2
`define MD_L4 2'h3
`define FWD_UNIT_BIT 4
`define FWD_ALG_BIT 3
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 200
`define US_CYCLES (`CLK_MHZ * 1)
`define MS_PER_US 1000
`endif

// [src/acl_tick_gen.v]
`timescale 1ns/1ps
`default_nettype none
module acl_tick_gen (
	// Clock and reset
	input wire clk_sys_i,
	input wire srst_i,
	// Unit ticks
	output reg us_tick_o,
	output reg ms_tick_o
);
`include "acl_rule_map.vh"
	localparam integer US_LAST = `US_CYCLES - 1;
	localparam integer MS_LAST = `MS_PER_US - 1;
	reg [7:0] us_cnt_q;
	reg [9:0] ms_cnt_q;
	always @(posedge clk_sys_i) begin
		if (srst_i) begin
			us_cnt_q <= 8'h00;
			ms_cnt_q <= 10'h000;
			us_tick_o <= 1'b0;
			ms_tick_o <= 1'b0;
		end else begin
			us_tick_o <= 1'b0;
			ms_tick_o <= 1'b0;
			if (us_cnt_q == US_LAST[7:0]) begin
				us_cnt_q <= 8'h00;
				us_tick_o <= 1'b1;
				if (ms_cnt_q == MS_LAST[9:0]) begin
					ms_cnt_q <= 10'h000;
					ms_tick_o <= 1'b1;
				end else begin
					ms_cnt_q <= ms_cnt_q + 10'h001;
				end
			end else begin
				us_cnt_q <= us_cnt_q + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// [verif/acl_rule_match_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module acl_rule_match_monitor (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// Watched ports
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic pkt_valid_i,
	input wire logic match_o,
	input wire logic match_valid_o,
	input wire logic [1:0] match_kind_o,
	input wire logic irq_o,
	input wire logic [10:0] count_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	sequence s_rd_unmapped;
		reg_rd_i && !(reg_addr_i inside {8'h6e, 8'h6f, 8'ha0});
	endsequence
	property p_mv_cause;
		match_valid_o |-> $past(pkt_valid_i);
	endproperty
	a_mv_cause: assert property (p_mv_cause) else $error("eval without packet");
	property p_mv_kind;
		match_valid_o |-> match_kind_o != 2'h0;
	endproperty
	a_mv_kind: assert property (p_mv_kind) else $error("eval with rule off");
	property p_match_qual;
		match_o |-> match_valid_o;
	endproperty
	a_match_qual: assert property (p_match_qual) else $error("match not qualified");
	property p_irq_pulse;
		irq_o |=> !irq_o;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
	property p_irq_count;
		irq_o |-> ##[0:1] count_o == 11'h000;
	endproperty
	a_irq_count: assert property (p_irq_count) else $error("count not cleared");
	property p_rd_hold;
		!$past(reg_rd_i) |-> $stable(reg_rdata_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_unmapped;
		s_rd_unmapped |=> reg_rdata_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
	property p_reset;
		$past(srst_i) |-> !irq_o && !match_valid_o && count_o == 11'h000;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not reset");
endmodule
bind acl_rule_match_control acl_rule_match_monitor u_mon (.clk_sys_i, .srst_i, .reg_addr_i,
	.reg_rd_i, .reg_rdata_o, .pkt_valid_i, .match_o, .match_valid_o, .match_kind_o, .irq_o,
	.count_o);
`default_nettype wire

// [verif/acl_rule_match_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module acl_rule_match_control_tb;
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic pkt_valid_i = 1'b0;
	logic [47:0] pkt_da_i = 48'h0;
	logic [15:0] pkt_type_i = 16'h0;
	logic [31:0] pkt_ip_da_i = 32'h0;
	logic [31:0] pkt_ip_sa_i = 32'h0;
	logic [7:0] pkt_proto_i = 8'h00;
	logic [15:0] pkt_sport_i = 16'h0;
	logic [31:0] pkt_seq_i = 32'h0;
	wire [7:0] reg_rdata_o;
	wire match_o, match_valid_o, irq_o;
	wire [1:0] match_kind_o;
	wire [10:0] count_o;
	int fails = 0;
	int check_count = 0;
	int n;
	logic [10:0] rv;
	logic [10:0] r;
	localparam logic [47:0] MAC = 48'h0a1b2c3d4e5f;
	localparam logic [15:0] TYP = 16'h88b5;
	localparam logic [47:0] L3A = 48'h0a00ff000000;
	always #2.5 clk_sys_i = ~clk_sys_i;
	acl_rule_match_control u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pkt_valid_i(pkt_valid_i),
		.pkt_da_i(pkt_da_i), .pkt_sa_i(~pkt_da_i), .pkt_type_i(pkt_type_i),
		.pkt_ip_da_i(pkt_ip_da_i), .pkt_ip_sa_i(pkt_ip_sa_i), .pkt_proto_i(pkt_proto_i),
		.pkt_dport_i(pkt_type_i), .pkt_sport_i(pkt_sport_i), .pkt_seq_i(pkt_seq_i),
		.match_o(match_o), .match_valid_o(match_valid_o), .match_kind_o(match_kind_o),
		.irq_o(irq_o), .count_o(count_o));
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [10:0] e, input logic [10:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		#1;
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(posedge clk_sys_i);
		#1;
		reg_wr_i = 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk_sys_i);
		#1;
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(posedge clk_sys_i);
		#1;
		reg_rd_i = 1'b0;
		rv = {3'h0, reg_rdata_o};
	endtask
	task ent(input logic [7:0] off, input logic [7:0] d);
		wr(8'h6e, 8'h40);
		wr(8'h6f, off);
		wr(8'ha0, d);
	endtask
	task pkt(input logic [47:0] da, input logic [15:0] ty);
		@(posedge clk_sys_i);
		#1;
		pkt_da_i = da;
		pkt_type_i = ty;
		pkt_valid_i = 1'b1;
		@(posedge clk_sys_i);
		#1;
		pkt_valid_i = 1'b0;
		r = {6'h0, irq_o, match_kind_o, match_valid_o, match_o};
	endtask
	task t_regs;
		wr(8'h6e, 8'h40);
		wr(8'h6f, 8'h01);
		rd(8'ha0);
		chk("mode reset", 11'h000, rv);
		wr(8'ha0, 8'hff);
		rd(8'ha0);
		chk("mode rw", 11'h03f, rv);
		wr(8'h6e, 8'h00);
		rd(8'ha0);
		chk("refused", 11'h000, rv);
		rd(8'h55);
		chk("unmapped", 11'h000, rv);
	endtask
	task t_l2;
		for (int i = 0; i < 6; i++) begin
			ent(8'h02 + 8'(i), MAC[47 - 8 * i -: 8]);
		end
		ent(8'h08, TYP[15:8]);
		ent(8'h09, TYP[7:0]);
		ent(8'h01, 8'h1d);
		pkt(MAC, TYP);
		chk("l2 both", 11'h007, r);
		pkt(MAC, TYP ^ 16'h1);
		chk("l2 type", 11'h006, r);
		ent(8'h01, 8'h1f);
		pkt(MAC, TYP);
		chk("l2 sa", 11'h006, r);
		ent(8'h01, 8'h14);
		pkt(MAC ^ 48'h1, TYP);
		chk("l2 neq", 11'h007, r);
		pkt(MAC, TYP);
		chk("l2 eq0", 11'h006, r);
		ent(8'h01, 8'h19);
		pkt(MAC, 16'h0);
		chk("l2 mac", 11'h007, r);
		ent(8'h01, 8'h00);
		pkt(MAC, TYP);
		chk("off", 11'h000, r);
	endtask
	task t_l4;
		ent(8'h01, 8'h35);
		pkt(MAC, TYP);
		chk("port 01", 11'h00f, r);
		ent(8'h01, 8'h39);
		pkt(MAC, TYP);
		chk("port 10", 11'h00f, r);
		ent(8'h01, 8'h37);
		pkt(MAC, TYP);
		chk("port sa ne", 11'h00e, r);
		pkt_sport_i = TYP;
		pkt(MAC, TYP);
		chk("port sa eq", 11'h00f, r);
		ent(8'h01, 8'h31);
		pkt_proto_i = TYP[7:0];
		pkt(MAC, TYP);
		chk("proto eq", 11'h00f, r);
		pkt_proto_i = 8'h06;
		pkt(MAC, TYP);
		chk("proto ne", 11'h00e, r);
		ent(8'h01, 8'h3d);
		pkt_seq_i = MAC[31:0];
		pkt(MAC, TYP);
		chk("seq eq", 11'h00f, r);
		pkt_seq_i = ~MAC[31:0];
		pkt(MAC, TYP);
		chk("seq ne", 11'h00e, r);
	endtask
	task t_l3;
		for (int i = 0; i < 6; i++) begin
			ent(8'h02 + 8'(i), L3A[47 - 8 * i -: 8]);
		end
		ent(8'h01, 8'h25);
		pkt_ip_da_i = 32'h0a123456;
		pkt_ip_sa_i = 32'h0b000000;
		pkt(MAC, TYP);
		chk("ip da", 11'h00b, r);
		ent(8'h01, 8'h27);
		pkt(MAC, TYP);
		chk("ip sa", 11'h00a, r);
		ent(8'h01, 8'h29);
		pkt(MAC, TYP);
		chk("sa ne da", 11'h00a, r);
		pkt_ip_sa_i = 32'h0a123456;
		pkt(MAC, TYP);
		chk("sa eq da", 11'h00b, r);
		ent(8'h01, 8'h21);
		pkt(MAC, TYP);
		chk("l3 rsvd 00", 11'h00a, r);
		ent(8'h01, 8'h2d);
		pkt(MAC, TYP);
		chk("l3 rsvd 11", 11'h00a, r);
		for (int i = 4; i < 8; i++) begin
			ent(8'(i), 8'h00);
		end
		ent(8'h01, 8'h25);
		pkt_proto_i = TYP[7:0];
		pkt(MAC, TYP);
		chk("ip proto eq", 11'h00b, r);
		pkt_proto_i = 8'h06;
		pkt(MAC, TYP);
		chk("ip proto ne", 11'h00a, r);
	endtask
	task t_up;
		ent(8'h0a, 8'hf8);
		ent(8'h0b, 8'h03);
		ent(8'h0c, 8'h08);
		ent(8'h01, 8'h11);
		for (int k = 1; k < 4; k++) begin
			pkt(MAC, TYP);
			chk("up irq", 11'(k == 3), {10'h0, r[4]});
		end
		@(posedge clk_sys_i);
		#1;
		chk("up clear", 11'h000, count_o);
	endtask
	task t_down;
		ent(8'h0c, 8'h00);
		ent(8'h0b, 8'h02);
		ent(8'h01, 8'h00);
		ent(8'h01, 8'h11);
		repeat (250) @(posedge clk_sys_i);
		pkt(MAC, TYP);
		n = 0;
		while (irq_o !== 1'b1 && n < 1000) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		if (n == 1000) begin
			fails++;
		end else begin
			chk("timeout", 11'h001, 11'(n >= 200 && n <= 410));
		end
	endtask
	initial begin
		repeat (12) @(posedge clk_sys_i);
		#1;
		srst_i = 1'b0;
		t_regs;
		t_l2;
		t_l4;
		t_up;
		t_down;
		t_l3;
		end_of_test;
	end
endmodule
`default_nettype wire
